// file: bench/pia_host_model.sv
// Host processor model: issues one register access at a time to the aggregator.
// Assumes strobes are taken at a rising edge and read data lands one cycle later.
`timescale 1ns/100ps

module pia_host_model (
  // Clock and line.
  input wire logic core_clk_i,
  input wire logic int_i,
  // Register access.
  input wire logic [7:0] reg_rdata_i,
  output pia_pkg::pia_access_t reg_req_o
);
  // Idle from time zero so no stray strobe reaches the block.
  initial begin
    reg_req_o = '0;
  end

  // One access; the idle cycle in front keeps strobes one cycle wide.
  task automatic acc(input logic rd, input logic wr, input logic [4:0] addr,
    input logic [7:0] wdata, output logic [7:0] data);
    @(posedge core_clk_i);
    #5;
    reg_req_o = {rd, wr, addr, wdata};
    @(posedge core_clk_i);
    #5;
    reg_req_o = '0;
    data = reg_rdata_i;
  endtask : acc

  // Reads every group in turn, so two clears never hit one address
  // back to back, and repeats, for up to four passes, while the line stays at its active level.
  task automatic clear_pass(input logic act_lvl);
    logic [7:0] d;
    for (int p = 0; p < 4; p++) begin
      if (int_i === act_lvl) begin
        for (int g = 0; g < 4; g++) begin
          acc(1'b1, 1'b0, pia_pkg::A_STAT + 5'(g), 8'h00, d);
        end
      end
    end
  endtask : clear_pass
endmodule : pia_host_model

// file: bench/tb_top.sv
// Self-checking bench of the interrupt aggregator driven by the host model.
// Assumes the package register map and a 20 MHz core clock.
`timescale 1ns/100ps

module tb_top;
  localparam int DLY = 5;
  logic core_clk_i, arst_n_i, sup, hot, pdn, rem, btn, sht, rin, wdg;
  logic int_o, on_req, slp_rdy;
  logic [7:0] reg_rdata, g3, g4, d;
  pia_pkg::pia_access_t reg_req;
  pia_pkg::pia_pwr_t pwr;
  int fail_count, samples_checked, cyc;

  pia_aggregator #(.HOLD_CNT_W(16)) i_pia_aggregator (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req),
    .reg_rdata_o(reg_rdata), .pwr_state_i(pwr), .supply_voltage_monitor_i(sup),
    .die_overheat_warning_i(hot), .power_down_pin_i(pdn), .remote_switch_on_i(rem),
    .power_button_i(btn), .output_short_i(sht), .reset_in_pin_i(rin),
    .watchdog_timeout_i(wdg), .group3_src_i(g3), .group4_src_i(g4),
    .int_o(int_o), .on_request_o(on_req), .sleep_ready_o(slp_rdy));

  pia_host_model i_pia_host_model (
    .core_clk_i(core_clk_i), .int_i(int_o), .reg_rdata_i(reg_rdata),
    .reg_req_o(reg_req));

  // Free-running 50 ns clock.
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Cycle ceiling; the whole run needs well under a thousand cycles.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    i_pia_host_model.acc(1'b1, 1'b0, a, 8'h00, d);
    chk(d, exp);
  endtask : rdc

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_pia_host_model.acc(1'b0, 1'b1, a, v, d);
  endtask : wr

  // Waits past the synchroniser and flag latency with inputs off the edge.
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #DLY;
  endtask : wt

  task automatic t_reset();
    chk(int_o, 1'b1);
    chk(on_req, 1'b0);
    chk(slp_rdy, 1'b1);
    rdc(pia_pkg::A_ICTRL, pia_pkg::ICTRL_RST);
    rdc(pia_pkg::A_MASK, pia_pkg::MASK_RST);
    rdc(5'h1f, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_read_clear();
    sup = 1'b1;
    sht = 1'b1;
    wt(6);
    chk(int_o, 1'b0);
    chk(on_req, 1'b1);
    chk(slp_rdy, 1'b0);
    rdc(pia_pkg::A_LIVE, 8'h42);
    rdc(pia_pkg::A_STAT, 8'h40);
    chk(int_o, 1'b0);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h40);
    wt(2);
    chk(int_o, 1'b1);
    wr(pia_pkg::A_EDGE_A, 8'h01);
    g4 = 8'h01;
    wt(6);
    rdc(pia_pkg::A_STAT + 5'h3, 8'h01);
    $display("clear on read test done");
  endtask : t_read_clear

  task automatic t_mask();
    wr(pia_pkg::A_MASK, 8'h40);
    sup = 1'b0;
    wt(6);
    chk(int_o, 1'b1);
    rdc(pia_pkg::A_STAT, 8'h00);
    wr(pia_pkg::A_MASK, 8'h00);
    sup = 1'b1;
    wt(6);
    wr(pia_pkg::A_MASK, 8'h40);
    sup = 1'b0;
    wt(6);
    rdc(pia_pkg::A_STAT, 8'h40);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h00);
    rdc(pia_pkg::A_STAT, 8'h00);
    wr(pia_pkg::A_MASK, 8'h00);
    $display("mask test done");
  endtask : t_mask

  task automatic t_pending();
    sup = 1'b1;
    wt(6);
    sup = 1'b0;
    wt(6);
    rdc(pia_pkg::A_STAT, 8'h40);
    rdc(pia_pkg::A_STAT, 8'h40);
    chk(int_o, 1'b0);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h00);
    rdc(pia_pkg::A_STAT, 8'h40);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h00);
    wt(2);
    chk(int_o, 1'b1);
    $display("pending test done");
  endtask : t_pending

  task automatic t_write_clear();
    wr(pia_pkg::A_ICTRL, 8'h02);
    sup = 1'b1;
    wt(6);
    wdg = 1'b1;
    wt(6);
    sup = 1'b0;
    wt(6);
    rdc(pia_pkg::A_STAT, 8'h40);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h04);
    wr(pia_pkg::A_STAT, 8'hbf);
    rdc(pia_pkg::A_STAT + 5'h1, 8'h04);
    rdc(pia_pkg::A_STAT, 8'h40);
    wr(pia_pkg::A_STAT + 5'h1, 8'hff);
    wr(pia_pkg::A_STAT, 8'h40);
    rdc(pia_pkg::A_STAT, 8'h00);
    chk(int_o, 1'b1);
    wr(pia_pkg::A_ICTRL, pia_pkg::ICTRL_RST);
    $display("clear on write test done");
  endtask : t_write_clear

  task automatic t_sleep();
    wr(pia_pkg::A_ICTRL, 8'h05);
    wt(2);
    chk(int_o, 1'b0);
    wr(pia_pkg::A_OSC, 8'h01);
    pwr = pia_pkg::PIA_SLEEP;
    rin = 1'b1;
    wt(6);
    chk(int_o, 1'b0);
    chk(slp_rdy, 1'b0);
    pwr = pia_pkg::PIA_ACTIVE;
    wt(2);
    chk(int_o, 1'b1);
    i_pia_host_model.clear_pass(1'b1);
    wr(pia_pkg::A_ICTRL, pia_pkg::ICTRL_RST);
    wr(pia_pkg::A_OSC, pia_pkg::OSC_RST);
    chk(slp_rdy, 1'b1);
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_off();
    pwr = pia_pkg::PIA_OFF;
    hot = 1'b1;
    rem = 1'b1;
    wt(6);
    rdc(pia_pkg::A_STAT, 8'h00);
    pwr = pia_pkg::PIA_ACTIVE;
    hot = 1'b0;
    pdn = 1'b1;
    g3 = 8'h81;
    wt(6);
    // A read of another group in between re-arms clearing of group 1.
    rdc(pia_pkg::A_STAT + 5'h2, 8'h81);
    rdc(pia_pkg::A_STAT, 8'h30);
    rem = 1'b0;
    btn = 1'b0;
    wt(6);
    btn = 1'b1;
    rdc(pia_pkg::A_STAT + 5'h1, 8'h00);
    rdc(pia_pkg::A_STAT, 8'h0a);
    // Long press: one delay step is 256 cycles, so the hold flag is up well before 270.
    wr(pia_pkg::A_HOLD, 8'h01);
    btn = 1'b0;
    wt(270);
    rdc(pia_pkg::A_LIVE, 8'h14);
    rdc(pia_pkg::A_STAT, 8'h06);
    btn = 1'b1;
    $display("power state test done");
  endtask : t_off

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Button idles high so its falling detector sees nothing at release.
  initial begin
    {sup, hot, pdn, rem, sht, rin, wdg} = '0;
    btn = 1'b1;
    g3 = 8'h00;
    g4 = 8'h00;
    pwr = pia_pkg::PIA_ACTIVE;
    fail_count = 0;
    samples_checked = 0;
    cyc = 0;
    arst_n_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    #DLY;
    arst_n_i = 1'b1;
    wt(1);
    t_reset();
    t_read_clear();
    t_mask();
    t_pending();
    t_write_clear();
    t_sleep();
    t_off();
    end_sim();
  end
endmodule : tb_top

// file: verilog/pia_aggregator.sv
// Interrupt aggregator of a power-management device: four source groups,
// each with event flags, source blocking and live levels, one shared line.
// Assumes one register access per cycle from the control interface and
// event inputs that are levels, synchronised here before edge detection.
//
// Operation
// - Four groups, each with event flags, source block and live level registers.
// - Group 4 has separate rising and falling edge select registers.
// - All flags combine onto one interrupt line, active low after reset.
// - A blocked source never sets its flag nor raises the line; events lost.
// - A flag set before blocking stays until cleared; no new events set it.
// - Active line is a switch-on request; sleep waits for unblocked flags clear.
// - Software picks line polarity and clearing method in the control register.
// - A bit of the osc register decides whether the line reaches the host in sleep.
// - With pending on, a repeat event is held once; two clears are needed.
// - Two back-to-back clears of one register clear only one interrupt.
// - With pending off, repeat events on a flagged source are discarded.
// - An event on an unflagged source sets its flag at once.
// - Outside masked sleep, the line is released only when all flags of all groups are clear.
// - One control bit selects clear-on-read or clear-on-write for every flag.
// - Clear-on-read clears all eight bits of the read register only.
// - Clear-on-write clears only bits written with one.
// - Group 1 holds supply, overheat, power-down, remote, hold and button.
// - Remote and button falling edges always request switch-on; hold uses delay.
// - Overheat, remote and button events only outside the off state.
// - Group 2 holds short, reset-in and watchdog, all rising edges.
`timescale 1ns/100ps

module pia_aggregator #(
  parameter int HOLD_CNT_W = 16
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Register access from the control interface.
  input wire pia_pkg::pia_access_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Device power state.
  input wire pia_pkg::pia_pwr_t pwr_state_i,
  // Group 1 and group 2 source lines.
  input wire logic supply_voltage_monitor_i,
  input wire logic die_overheat_warning_i,
  input wire logic power_down_pin_i,
  input wire logic remote_switch_on_i,
  input wire logic power_button_i,
  input wire logic output_short_i,
  input wire logic reset_in_pin_i,
  input wire logic watchdog_timeout_i,
  // Group 3 and group 4 source lines.
  input wire logic [7:0] group3_src_i,
  input wire logic [7:0] group4_src_i,
  // Results.
  output logic int_o,
  output logic on_request_o,
  output logic sleep_ready_o
);

  // The hold counter must cover the delay register shifted by the unit.
  if (HOLD_CNT_W < pia_pkg::GW + pia_pkg::HOLD_UNIT_W) begin : g_chk
    $error("HOLD_CNT_W too small for the hold delay");
  end

  // Register selection, used for the flag clear and block write decodes.
  function automatic logic reg_sel(input logic [4:0] addr, input logic [4:0] base,
                                   input int grp);
    reg_sel = (addr == 5'(base + 5'(grp)));
  endfunction : reg_sel

  logic [3:0][7:0] raw;
  logic [3:0][7:0] sync_a;
  logic [3:0][7:0] sync_b;
  logic [3:0][7:0] live;
  logic [3:0][7:0] prev;
  logic [3:0][7:0] rise;
  logic [3:0][7:0] fall;
  logic [3:0][7:0] gate;
  logic [3:0][7:0] ev;
  logic [3:0][7:0] qual;
  logic [3:0][7:0] clr;
  logic [3:0][7:0] stat;
  logic [3:0][7:0] pend;
  logic [3:0][7:0] mask;
  logic [3:0][7:0] s_after;
  logic [3:0][7:0] next_stat;
  logic [3:0][7:0] next_pend;
  logic [7:0] edge_a;
  logic [7:0] edge_b;
  logic [7:0] ictrl;
  logic [7:0] osc;
  logic [7:0] hold_delay;
  logic [HOLD_CNT_W-1:0] hold_cnt;
  logic hold_flag;
  logic [4:0] last_addr;
  logic last_clr;
  logic acc;
  logic stat_addr;
  logic clr_acc;
  logic clr_eff;
  logic awake;
  logic any_stat;
  logic line_act;
  logic on_pin;

  // Gather the source lines into the four groups.
  assign raw[0] = {1'b0, supply_voltage_monitor_i, die_overheat_warning_i,
                   power_down_pin_i, remote_switch_on_i, 1'b0, power_button_i, 1'b0};
  assign raw[1] = {1'b0, output_short_i, 1'b0, reset_in_pin_i, 1'b0,
                   watchdog_timeout_i, 2'b00};
  assign raw[2] = group3_src_i;
  assign raw[3] = group4_src_i;

  // Two-stage synchroniser; only the second stage feeds the edge logic,
  // so each qualifying edge is seen exactly once.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
      prev <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      prev <= live;
    end
  end

  // Count how long the button has stayed low; saturates instead of wrapping.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_cnt <= '0;
    end else if (sync_b[0][pia_pkg::G1_BUTTON]) begin
      hold_cnt <= '0;
    end else if (!(&hold_cnt)) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // One delay step is a fixed block of clock cycles to keep the register narrow.
  assign hold_flag = !sync_b[0][pia_pkg::G1_BUTTON] &&
                     (hold_cnt >= HOLD_CNT_W'({hold_delay, 8'h00}));

  // Live levels shown to software; the hold source shows its held state.
  always_comb begin
    live = sync_b;
    live[0][pia_pkg::G1_HOLD] = hold_flag;
  end

  // Edge enables per group and the power-state gate.
  assign awake = (pwr_state_i != pia_pkg::PIA_OFF);
  assign rise[0] = pia_pkg::G1_RISE;
  assign fall[0] = pia_pkg::G1_FALL;
  assign rise[1] = pia_pkg::G2_RISE;
  assign fall[1] = pia_pkg::NO_EDGE;
  assign rise[2] = pia_pkg::G3_RISE;
  assign fall[2] = pia_pkg::NO_EDGE;
  assign rise[3] = edge_a;
  assign fall[3] = edge_b;
  assign gate[0] = awake ? 8'hff : ~pia_pkg::G1_AWAKE_ONLY;
  assign gate[1] = 8'hff;
  assign gate[2] = 8'hff;
  assign gate[3] = 8'hff;

  // Edge detection per group; a blocked source still detects edges but qualifies none.
  for (genvar g = 0; g < pia_pkg::NGRP; g++) begin : g_edge
    assign ev[g] = (rise[g] & live[g] & ~prev[g]) | (fall[g] & ~live[g] & prev[g]);
    assign qual[g] = ev[g] & gate[g] & ~mask[g];
  end

  // Clearing access decode. A second clear of the same register with no
  // other access between is ignored, so only one interrupt goes per pair.
  assign acc = reg_req_i.rd | reg_req_i.wr;
  assign stat_addr = (reg_req_i.addr[4:2] == pia_pkg::A_STAT[4:2]);
  assign clr_acc = stat_addr &&
                   (ictrl[pia_pkg::B_CLR_WR] ? reg_req_i.wr : reg_req_i.rd);
  assign clr_eff = clr_acc && !(last_clr && last_addr == reg_req_i.addr);

  // Per-group clear vector: whole register on read, written ones on write.
  for (genvar g = 0; g < pia_pkg::NGRP; g++) begin : g_clr
    assign clr[g] = (clr_eff && reg_sel(reg_req_i.addr, pia_pkg::A_STAT, g)) ?
                    (ictrl[pia_pkg::B_CLR_WR] ? reg_req_i.wdata : 8'hff) : 8'h00;
  end

  // Remember the last access for the back-to-back guard.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_addr <= '0;
      last_clr <= 1'b0;
    end else if (acc) begin
      last_addr <= reg_req_i.addr;
      last_clr <= clr_acc;
    end
  end

  // Flag update. A clear first consumes a pending event, then the flag.
  // An event in the same cycle as its clear still lands: set wins.
  assign s_after = stat & (pend | ~clr);
  assign next_stat = s_after | qual;
  assign next_pend = (pend & ~clr) |
                     (qual & s_after & {32{ictrl[pia_pkg::B_PEND]}});

  // Flag and pending storage.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat <= '0;
      pend <= '0;
    end else begin
      stat <= next_stat;
      pend <= next_pend;
    end
  end

  // Writable configuration registers.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask <= {4{pia_pkg::MASK_RST}};
      edge_a <= pia_pkg::EDGE_RST;
      edge_b <= pia_pkg::EDGE_RST;
      ictrl <= pia_pkg::ICTRL_RST;
      osc <= pia_pkg::OSC_RST;
      hold_delay <= pia_pkg::HOLD_RST;
    end else if (reg_req_i.wr) begin
      for (int g = 0; g < pia_pkg::NGRP; g++) begin
        if (reg_sel(reg_req_i.addr, pia_pkg::A_MASK, g)) begin
          mask[g] <= reg_req_i.wdata;
        end
      end
      if (reg_req_i.addr == pia_pkg::A_EDGE_A) begin
        edge_a <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == pia_pkg::A_EDGE_B) begin
        edge_b <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == pia_pkg::A_ICTRL) begin
        ictrl <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == pia_pkg::A_OSC) begin
        osc <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == pia_pkg::A_HOLD) begin
        hold_delay <= reg_req_i.wdata;
      end
    end
  end

  // Read data, returned the cycle after the read; unmapped reads give zero.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr[4:2])
        3'h0: reg_rdata_o <= stat[reg_req_i.addr[1:0]];
        3'h1: reg_rdata_o <= mask[reg_req_i.addr[1:0]];
        3'h2: reg_rdata_o <= live[reg_req_i.addr[1:0]];
        3'h3: begin
          case (reg_req_i.addr[1:0])
            2'h0: reg_rdata_o <= edge_a;
            2'h1: reg_rdata_o <= edge_b;
            2'h2: reg_rdata_o <= ictrl;
            default: reg_rdata_o <= osc;
          endcase
        end
        3'h4: reg_rdata_o <= (reg_req_i.addr[1:0] == 2'h0) ? hold_delay : 8'h00;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Line state. Remote and button edges request switch-on whatever the mask.
  assign any_stat = |stat;
  assign line_act = any_stat &&
                    !(pwr_state_i == pia_pkg::PIA_SLEEP && osc[pia_pkg::B_SLEEP_MASK]);
  assign on_pin = |(ev[0] & pia_pkg::G1_ON_SRC);

  // Registered outputs; the line idles high for the default low polarity.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_o <= 1'b1;
      on_request_o <= 1'b0;
      sleep_ready_o <= 1'b1;
    end else begin
      int_o <= ictrl[pia_pkg::B_POL] ? line_act : !line_act;
      on_request_o <= any_stat | on_pin;
      sleep_ready_o <= !(|(stat & ~mask));
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // A clearing access followed at once by a clear of the same register.
  sequence s_clear_acc;
    clr_acc && !last_clr;
  endsequence
  sequence s_same_again;
    clr_acc && reg_req_i.addr == $past(reg_req_i.addr);
  endsequence

  a_back_to_back: assert property (s_clear_acc ##1 s_same_again |-> clr == '0)
    else $error("second back-to-back clear took effect");

  // Idle cycles do not re-arm the guard; only an access elsewhere or a non-clearing access does.
  sequence s_same_skip;
    clr_acc && reg_req_i.addr == $past(reg_req_i.addr, 2);
  endsequence

  a_guard_idle: assert property (s_clear_acc ##1 !acc ##1 s_same_skip |-> clr == '0)
    else $error("repeat clear after an idle cycle took effect");

  a_mask_blocks_set: assert property (
    1 |=> ((stat & ~$past(stat) & $past(mask)) == '0))
    else $error("blocked source set its flag");

  a_masked_kept: assert property (
    1 |=> (($past(stat & ~clr) & ~stat) == '0))
    else $error("flag dropped without a clear");

  a_new_source: assert property (
    1 |=> (($past(qual & ~stat) & ~stat) == '0))
    else $error("event on unflagged source not stored");

  a_clear_done: assert property (
    1 |=> (($past(clr & ~pend & ~qual) & stat) == '0))
    else $error("cleared flag still set");

  a_pend_off: assert property (
    1 |=> (((pend & ~$past(pend)) & {32{!$past(ictrl[pia_pkg::B_PEND])}}) == '0))
    else $error("pending stored while disabled");

  a_pend_has_flag: assert property ((pend & ~stat) == '0)
    else $error("pending event without its flag");

  a_line_release: assert property (
    !any_stat && !ictrl[pia_pkg::B_POL] |=> int_o)
    else $error("line active with all flags clear");

  a_line_low: assert property (
    line_act && !ictrl[pia_pkg::B_POL] |=> !int_o)
    else $error("line not driven low for a flag");

  a_on_button: assert property (on_pin |=> on_request_o)
    else $error("button edge gave no switch-on request");

  a_sleep_wait: assert property (|(stat & ~mask) |=> !sleep_ready_o)
    else $error("sleep allowed with unblocked flag");

  a_off_gate: assert property (
    pwr_state_i == pia_pkg::PIA_OFF |-> (qual[0] & pia_pkg::G1_AWAKE_ONLY) == 8'h00)
    else $error("awake-only source fired while off");

endmodule : pia_aggregator

// file: verilog/pia_pkg.sv
// Package of the interrupt aggregator: register indices, field positions,
// reset values, source bit positions and the register access carrier.
// Assumes the control interface delivers one decoded access per cycle.
package pia_pkg;

  // Group geometry.
  localparam int NGRP = 4;
  localparam int GW = 8;
  localparam int ADDR_W = 5;

  // Register indices; group g of a bank sits at base plus g.
  localparam logic [4:0] A_STAT = 5'h00;
  localparam logic [4:0] A_MASK = 5'h04;
  localparam logic [4:0] A_LIVE = 5'h08;
  localparam logic [4:0] A_EDGE_A = 5'h0c;
  localparam logic [4:0] A_EDGE_B = 5'h0d;
  localparam logic [4:0] A_ICTRL = 5'h0e;
  localparam logic [4:0] A_OSC = 5'h0f;
  localparam logic [4:0] A_HOLD = 5'h10;

  // Interrupt control fields and reset values.
  localparam int B_POL = 0;
  localparam int B_CLR_WR = 1;
  localparam int B_PEND = 2;
  localparam logic [7:0] ICTRL_RST = 8'h04;
  localparam int B_SLEEP_MASK = 0;
  localparam logic [7:0] OSC_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'h10;
  localparam int HOLD_UNIT_W = 8;

  // Source bit positions of groups 1 and 2.
  localparam int G1_SUPPLY = 6;
  localparam int G1_HOT = 5;
  localparam int G1_PDN = 4;
  localparam int G1_REMOTE = 3;
  localparam int G1_HOLD = 2;
  localparam int G1_BUTTON = 1;
  localparam int G2_SHORT = 6;
  localparam int G2_RESETIN = 4;
  localparam int G2_WDOG = 2;

  // Fixed edge enables; group 4 takes its enables from registers.
  localparam logic [7:0] G1_RISE = 8'h74;
  localparam logic [7:0] G1_FALL = 8'h7a;
  localparam logic [7:0] G2_RISE = 8'h54;
  localparam logic [7:0] G3_RISE = 8'hff;
  localparam logic [7:0] NO_EDGE = 8'h00;
  localparam logic [7:0] G1_AWAKE_ONLY = 8'h2a;
  localparam logic [7:0] G1_ON_SRC = 8'h0a;

  typedef enum logic [1:0] {PIA_OFF, PIA_ACTIVE, PIA_SLEEP} pia_pwr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } pia_access_t;

endpackage : pia_pkg
